// ===== core/acmp_ctrl.sv
/*
 * acmp_ctrl: digital control, event detection and status for up to three
 * analog comparators, with an Avalon-MM register slave and a level interrupt.
 * Assumes the analog comparator cores sit outside: each delivers a raw result
 * and accepts enable, low-power and input-select levels from this block.
 */
`timescale 1ns/1ns
module acmp_ctrl
    import acmp_pkg::*;
#(
    parameter int NUM_COMP = 3    // 1 to 3 comparators
)
(
    // clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  srst_in,
    // avalon-mm slave
    input  wire logic [4:0]            avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    // device power state
    input  wire logic                  cpu_idle_in,
    // analog comparator cores
    input  wire logic [NUM_COMP-1:0]   comp_raw_in,
    output logic      [NUM_COMP-1:0]   comp_on_out,
    output logic      [NUM_COMP-1:0]   comp_low_power_out,
    output logic      [2*NUM_COMP-1:0] noninv_input_select_out,
    output logic      [2*NUM_COMP-1:0] inv_input_select_out,
    output logic      [NUM_COMP-1:0]   comp_invert_out,
    output logic      [NUM_COMP-1:0]   comp_pin_drive_en_out,
    // event triggers to other peripherals and interrupt
    output logic      [NUM_COMP-1:0]   comp_trigger_out,
    output logic                       irq_out
);

    // ==========================================================
    // shared signals
    logic [15:0]         ctrl_reg [NUM_COMP];
    logic [NUM_COMP-1:0] evt_flag;
    logic [NUM_COMP-1:0] res_sync1;
    logic [NUM_COMP-1:0] res_sync2;
    logic [NUM_COMP-1:0] res_pol;
    logic [NUM_COMP-1:0] res_prev;
    logic [NUM_COMP-1:0] armed_first;
    logic [NUM_COMP-1:0] evt_hit;
    logic                idle_irq_block;
    logic [NUM_COMP-1:0] irq_stat;
    logic [NUM_COMP-1:0] irq_mask;
    acmp_bus_state_type  bus_state;
    logic                wr_take;
    logic                rd_take;
    logic [15:0]         wdata16;

    // a write lands at the edge where waitrequest is seen low; read data is
    // captured one edge earlier so that it already stands at that edge
    assign wr_take = (bus_state == ACMP_BUS_ACK) && avs_write_in;
    assign rd_take = (bus_state == ACMP_BUS_IDLE) && avs_read_in;
    // only the low halfword is meaningful; control writes need both low lanes enabled
    assign wdata16 = avs_writedata_in[15:0];

    // ==========================================================
    // bus handshake: one wait cycle then ack
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            bus_state           <= ACMP_BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
        end
        else
        begin
            case (bus_state)
                ACMP_BUS_IDLE:
                begin
                    if (avs_read_in || avs_write_in)
                    begin
                        bus_state           <= ACMP_BUS_ACK;
                        avs_waitrequest_out <= 1'b0;
                    end
                end
                ACMP_BUS_ACK:
                begin
                    bus_state           <= ACMP_BUS_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
                default:
                begin
                    bus_state           <= ACMP_BUS_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // per-comparator logic
    genvar gi;
    generate
        for (gi = 0; gi < NUM_COMP; gi++)
        begin : g_comp
            logic [4:0] my_off;
            logic       my_wr;
            logic [1:0] edge_sel;
            assign my_off   = ACMP_OFF_CTRL1 + 5'(4 * gi);
            assign my_wr    = wr_take && (avs_address_in == my_off) && (avs_byteenable_in[1:0] == 2'h3);
            assign edge_sel = ctrl_reg[gi][ACMP_B_EDGE_LO +: 2];

            // control bits stored; reserved, result and flag bits never stored
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                    ctrl_reg[gi] <= ACMP_CTRL_RESET;
                else if (my_wr)
                    ctrl_reg[gi] <= wdata16 & ACMP_CTRL_WMASK & ~(16'h0001 << ACMP_B_EVT);
            end

            // two-flop synchroniser ahead of edge detection
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                begin
                    res_sync1[gi] <= 1'b0;
                    res_sync2[gi] <= 1'b0;
                end
                else
                begin
                    res_sync1[gi] <= comp_raw_in[gi];
                    res_sync2[gi] <= res_sync1[gi];
                end
            end

            // polarity applied before use; off comparator reads zero
            assign res_pol[gi] = ctrl_reg[gi][ACMP_B_ON] & (res_sync2[gi] ^ ctrl_reg[gi][ACMP_B_INV]);

            // edge decode; first event after arming takes any transition
            always_comb
            begin
                evt_hit[gi] = 1'b0;
                if (res_pol[gi] != res_prev[gi])
                begin
                    if (armed_first[gi])
                        evt_hit[gi] = 1'b1;
                    else
                    begin
                        case (edge_sel)
                            ACMP_EDGE_RISE: evt_hit[gi] = res_pol[gi];
                            ACMP_EDGE_FALL: evt_hit[gi] = ~res_pol[gi];
                            ACMP_EDGE_ANY:  evt_hit[gi] = 1'b1;
                            default:        evt_hit[gi] = 1'b0;
                        endcase
                    end
                end
                if (edge_sel == ACMP_EDGE_OFF)
                    evt_hit[gi] = 1'b0;
            end

            // previous result and first-event arming
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                begin
                    res_prev[gi]    <= 1'b0;
                    armed_first[gi] <= 1'b1;
                end
                else
                begin
                    res_prev[gi] <= res_pol[gi];
                    if (edge_sel == ACMP_EDGE_OFF)
                        armed_first[gi] <= 1'b1;
                    else if (evt_hit[gi] && !evt_flag[gi])
                        armed_first[gi] <= 1'b0;
                end
            end

            // sticky event flag: set wins over a software clear
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                    evt_flag[gi] <= 1'b0;
                else if (evt_hit[gi])
                    evt_flag[gi] <= 1'b1;
                else if (my_wr && !wdata16[ACMP_B_EVT])
                    evt_flag[gi] <= 1'b0;
            end

            // trigger pulse only while the flag is clear
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                    comp_trigger_out[gi] <= 1'b0;
                else
                    comp_trigger_out[gi] <= evt_hit[gi] && !evt_flag[gi];
            end

            // interrupt status: sticky, write one to clear, set wins
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                    irq_stat[gi] <= 1'b0;
                else if (evt_hit[gi] && !evt_flag[gi])
                    irq_stat[gi] <= 1'b1;
                else if (wr_take && avs_address_in == ACMP_OFF_IRQ_STAT && avs_writedata_in[gi])
                    irq_stat[gi] <= 1'b0;
            end

            // analog core controls, registered
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                begin
                    comp_on_out[gi]                  <= 1'b0;
                    comp_low_power_out[gi]           <= 1'b0;
                    comp_invert_out[gi]              <= 1'b0;
                    comp_pin_drive_en_out[gi]        <= 1'b0;
                    noninv_input_select_out[2*gi +: 2] <= ACMP_NINV_PIN_A;
                    inv_input_select_out[2*gi +: 2]    <= ACMP_INVS_PIN_B;
                end
                else
                begin
                    comp_on_out[gi]                  <= ctrl_reg[gi][ACMP_B_ON];
                    comp_low_power_out[gi]           <= ctrl_reg[gi][ACMP_B_LP];
                    comp_invert_out[gi]              <= ctrl_reg[gi][ACMP_B_INV];
                    // the pad muxes the raw result; no synchroniser in that path
                    comp_pin_drive_en_out[gi]        <= ctrl_reg[gi][ACMP_B_PIN];
                    noninv_input_select_out[2*gi +: 2] <= ctrl_reg[gi][ACMP_B_NINV_LO +: 2];
                    inv_input_select_out[2*gi +: 2]    <= ctrl_reg[gi][ACMP_B_INVS_LO +: 2];
                end
            end

            // flag follows hit by one edge, and no hit arises while the edge select is off
            AST_EVT_SET: assert property (@(posedge ref_clk_in) disable iff (srst_in)
                evt_hit[gi] |=> evt_flag[gi]) else $error("event flag not set after hit");
            AST_TRIG_MUTE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
                $past(evt_flag[gi]) && evt_flag[gi] |=> !comp_trigger_out[gi])
                else $error("trigger while event flag set");
            AST_EDGE_OFF: assert property (@(posedge ref_clk_in) disable iff (srst_in)
                edge_sel == ACMP_EDGE_OFF |-> !evt_hit[gi]) else $error("event with edge disabled");
            AST_RISE_ONLY: assert property (@(posedge ref_clk_in) disable iff (srst_in)
                edge_sel == ACMP_EDGE_RISE && !armed_first[gi] && evt_hit[gi] |-> res_pol[gi] && !res_prev[gi])
                else $error("rising event on wrong edge");
            AST_FIRST_ANY: assert property (@(posedge ref_clk_in) disable iff (srst_in)
                edge_sel != ACMP_EDGE_OFF && armed_first[gi] && res_pol[gi] != res_prev[gi] |-> evt_hit[gi])
                else $error("first transition missed");
            AST_SYNC_PATH: assert property (@(posedge ref_clk_in) disable iff (srst_in)
                ##2 ctrl_reg[gi][ACMP_B_ON] && !ctrl_reg[gi][ACMP_B_INV] && $stable(ctrl_reg[gi])
                |-> res_pol[gi] == $past(comp_raw_in[gi], 2)) else $error("result path latency wrong");
            AST_CTRL_OUT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
                ##1 1'b1 |-> comp_on_out[gi] == $past(ctrl_reg[gi][ACMP_B_ON])
                && comp_pin_drive_en_out[gi] == $past(ctrl_reg[gi][ACMP_B_PIN]))
                else $error("core control outputs do not follow register");
        end
    endgenerate

    // ==========================================================
    // idle-mode interrupt block bit, kept in the status register
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            idle_irq_block <= 1'b0;
        else if (wr_take && avs_address_in == ACMP_OFF_STATUS && avs_byteenable_in[1])
            idle_irq_block <= wdata16[ACMP_B_IDLE];
    end

    // interrupt mask register
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            irq_mask <= '0;
        else if (wr_take && avs_address_in == ACMP_OFF_IRQ_MASK && avs_byteenable_in[0])
            irq_mask <= avs_writedata_in[NUM_COMP-1:0];
    end

    // level interrupt; idle with the block bit set holds it low
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            irq_out <= 1'b0;
        else
            irq_out <= (|(irq_stat & irq_mask)) && !(idle_irq_block && cpu_idle_in);
    end

    AST_IDLE_BLOCK: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        idle_irq_block && cpu_idle_in |=> !irq_out) else $error("interrupt during blocked idle");

    // ==========================================================
    // read data mux; unmapped words and reserved bits read zero
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (rd_take)
        begin
            avs_readdata_out <= 32'h0000_0000;
            for (int i = 0; i < NUM_COMP; i++)
            begin
                if (avs_address_in == ACMP_OFF_CTRL1 + 5'(4 * i))
                begin
                    avs_readdata_out[15:0]        <= ctrl_reg[i];
                    avs_readdata_out[ACMP_B_EVT]  <= evt_flag[i];
                    avs_readdata_out[ACMP_B_RES]  <= res_pol[i];
                end
            end
            if (avs_address_in == ACMP_OFF_STATUS)
            begin
                avs_readdata_out[ACMP_B_IDLE] <= idle_irq_block;
                avs_readdata_out[ACMP_B_EVT_MIR +: NUM_COMP] <= evt_flag;
                avs_readdata_out[ACMP_B_RES_MIR +: NUM_COMP] <= res_pol;
            end
            if (avs_address_in == ACMP_OFF_IRQ_STAT)
                avs_readdata_out[NUM_COMP-1:0] <= irq_stat;
            if (avs_address_in == ACMP_OFF_IRQ_MASK)
                avs_readdata_out[NUM_COMP-1:0] <= irq_mask;
        end
    end

endmodule // acmp_ctrl

// ===== shared/acmp_pkg.sv
/*
 * acmp_pkg: register map, field positions, reset values and encodings for the
 * analog comparator event and control block.
 * Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
 */
package acmp_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [4:0] ACMP_OFF_CTRL1     = 5'h00;
    localparam logic [4:0] ACMP_OFF_CTRL2     = 5'h04;
    localparam logic [4:0] ACMP_OFF_CTRL3     = 5'h08;
    localparam logic [4:0] ACMP_OFF_STATUS    = 5'h0c;
    localparam logic [4:0] ACMP_OFF_IRQ_STAT  = 5'h10;
    localparam logic [4:0] ACMP_OFF_IRQ_MASK  = 5'h14;

    // ==========================================================
    // control register field positions
    localparam int ACMP_B_ON      = 15;
    localparam int ACMP_B_PIN     = 14;
    localparam int ACMP_B_INV     = 13;
    localparam int ACMP_B_LP      = 12;
    localparam int ACMP_B_EVT     = 9;
    localparam int ACMP_B_RES     = 8;
    localparam int ACMP_B_EDGE_LO = 6;
    localparam int ACMP_B_NINV_LO = 3;
    localparam int ACMP_B_INVS_LO = 0;

    // writable bits of a control register (bits 11,10,8,5,2 not stored)
    localparam logic [15:0] ACMP_CTRL_WMASK = 16'hf2db;
    localparam logic [15:0] ACMP_CTRL_RESET = 16'h0000;

    // ==========================================================
    // status register field positions
    localparam int ACMP_B_IDLE     = 15;
    localparam int ACMP_B_EVT_MIR  = 8;
    localparam int ACMP_B_RES_MIR  = 0;

    // ==========================================================
    // event edge select encodings
    localparam logic [1:0] ACMP_EDGE_OFF  = 2'h0;
    localparam logic [1:0] ACMP_EDGE_RISE = 2'h1;
    localparam logic [1:0] ACMP_EDGE_FALL = 2'h2;
    localparam logic [1:0] ACMP_EDGE_ANY  = 2'h3;

    // non-inverting input select encodings
    localparam logic [1:0] ACMP_NINV_PIN_A = 2'h0;
    localparam logic [1:0] ACMP_NINV_VREF  = 2'h1;
    localparam logic [1:0] ACMP_NINV_CONV1 = 2'h2;
    localparam logic [1:0] ACMP_NINV_CONV2 = 2'h3;

    // inverting input select encodings
    localparam logic [1:0] ACMP_INVS_PIN_B = 2'h0;
    localparam logic [1:0] ACMP_INVS_PIN_C = 2'h1;
    localparam logic [1:0] ACMP_INVS_PIN_D = 2'h2;
    localparam logic [1:0] ACMP_INVS_BGBUF = 2'h3;

    // bus slave states
    typedef enum logic [0:0] {ACMP_BUS_IDLE, ACMP_BUS_ACK} acmp_bus_state_type;

endpackage

// ===== tb/acmp_comp_model.sv
/*
 * acmp_comp_model: behavioural model of the three analog comparator cores.
 * Assumes the bench sets four 8-bit source levels for each comparator input
 * and that the block drives the enable and input select levels.
 */
`timescale 1ns/1ns
module acmp_comp_model
(
    // control levels from the block
    input  wire logic [2:0]  comp_on_in,
    input  wire logic [5:0]  noninv_sel_in,
    input  wire logic [5:0]  inv_sel_in,
    // source levels, one byte per select code
    input  wire logic [31:0] plus_lvl_in,
    input  wire logic [31:0] minus_lvl_in,
    // raw results
    output logic      [2:0]  comp_raw_out
);
    // ==========================================================
    // compare the selected sources; a core that is off reads low
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            comp_raw_out[i] = comp_on_in[i] &&
                (plus_lvl_in[8*noninv_sel_in[2*i+:2]+:8] >
                 minus_lvl_in[8*inv_sel_in[2*i+:2]+:8]);
        end
    end
endmodule // acmp_comp_model

// ===== tb/acmp_ctrl_tb.sv
/*
 * acmp_ctrl_tb: self-checking bench for the comparator control block.
 * Assumes the behavioural comparator model and a 125 MHz clock.
 */
`timescale 1ns/1ns
`define CHK(g, e) \
    begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module acmp_ctrl_tb
    import acmp_pkg::*;
;
    // ==========================================================
    // stimulus and observed signals
    logic        ref_clk     = 1'b0;
    logic        srst        = 1'b1;
    logic [4:0]  address     = 5'h00;
    logic        read        = 1'b0;
    logic        write       = 1'b0;
    logic [31:0] wdata       = 32'h0;
    logic        idle        = 1'b0;
    logic [31:0] plus_lvl    = 32'h1e3c0a28;
    logic [31:0] minus_lvl   = 32'h23053214;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        waitreq;
    logic        irq;
    logic [2:0]  raw, on, lp, inv, pin, trig;
    logic [5:0]  nsel, isel;
    logic [7:0]  trig_count  = 8'h00;
    int          fail_count  = 0;
    int          checks_done = 0;

    // ==========================================================
    // block and far-side model
    acmp_ctrl #(.NUM_COMP(3)) acmp_ctrl_inst
    (
        .ref_clk_in(ref_clk), .srst_in(srst), .avs_address_in(address), .avs_read_in(read),
        .avs_write_in(write), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .cpu_idle_in(idle),
        .comp_raw_in(raw), .comp_on_out(on), .comp_low_power_out(lp),
        .noninv_input_select_out(nsel), .inv_input_select_out(isel), .comp_invert_out(inv),
        .comp_pin_drive_en_out(pin), .comp_trigger_out(trig), .irq_out(irq)
    );
    acmp_comp_model acmp_comp_model_inst
    (
        .comp_on_in(on), .noninv_sel_in(nsel), .inv_sel_in(isel),
        .plus_lvl_in(plus_lvl), .minus_lvl_in(minus_lvl), .comp_raw_out(raw)
    );

    // clock at 8 ns period
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end

    // count trigger pulses of comparator 1; a stuck pulse counts many
    always @(posedge ref_clk)
    begin
        if (trig[0] === 1'b1)
        begin
            trig_count <= trig_count + 8'h01;
        end
    end

    // ==========================================================
    // bus master: holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        wdata <= d;
        write <= wr;
        read <= ~wr;
        @(posedge ref_clk);
        // no limit of its own: only the watchdog ends a wait that never answers
        while (waitreq !== 1'b0)
        begin
            @(posedge ref_clk);
        end
        q = rdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic end_sim();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // move the pin A level, settle through sync and flag, check pulses
    task automatic step(input logic [7:0] lvl, input logic [7:0] n);
        @(posedge ref_clk);
        plus_lvl[7:0] <= lvl;
        repeat (6) @(posedge ref_clk);
        `CHK(trig_count, n)
    endtask

    // ==========================================================
    // scenarios
    task automatic test_reset();
        for (int a = 0; a <= 24; a += 4)
        begin
            bus(1'b0, 5'(a), 32'h0);
            `CHK(q, 32'h0)
        end
        `CHK({on, lp, inv, pin, irq}, 13'h0)
    endtask

    // all writable bits set except the edge field; bit 9 write of one ignored
    task automatic test_ctrl();
        bus(1'b1, ACMP_OFF_CTRL1, 32'hffffff3f);
        repeat (4) @(posedge ref_clk);
        `CHK(on[0], 1'b1)
        `CHK(pin[0], 1'b1)
        `CHK(lp[0], 1'b1)
        `CHK(inv[0], 1'b1)
        bus(1'b0, ACMP_OFF_CTRL1, 32'h0);
        `CHK(q, 32'h0000f11b)
        bus(1'b1, ACMP_OFF_CTRL1, 32'h0);
    endtask

    // every select pair, both polarities, then comparators 2 and 3
    task automatic test_select();
        logic e;
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 4; i++)
                for (int j = 0; j < 4; j++)
                begin
                    bus(1'b1, ACMP_OFF_CTRL1, 32'(32'h8000 | (p << 13) | (i << 3) | j));
                    repeat (4) @(posedge ref_clk);
                    e = (plus_lvl[8*i+:8] > minus_lvl[8*j+:8]) ^ p[0];
                    `CHK({nsel[1:0], isel[1:0]}, {2'(i), 2'(j)})
                    bus(1'b0, ACMP_OFF_STATUS, 32'h0);
                    `CHK(q, {31'h0, e})
                end
        bus(1'b1, ACMP_OFF_CTRL1, 32'h0);
        bus(1'b1, ACMP_OFF_CTRL2, 32'h8010);
        bus(1'b1, ACMP_OFF_CTRL3, 32'ha009);
        repeat (4) @(posedge ref_clk);
        bus(1'b0, ACMP_OFF_STATUS, 32'h0);
        `CHK(q, 32'h6)
        `CHK(inv, 3'h4)
        `CHK({nsel, isel}, 12'h610)
        bus(1'b1, ACMP_OFF_CTRL2, 32'h0);
        bus(1'b1, ACMP_OFF_CTRL3, 32'h0);
    endtask

    // edge modes, first-any arming, muting while flagged, clear by zero
    task automatic test_event();
        bus(1'b1, ACMP_OFF_IRQ_MASK, 32'h1);
        bus(1'b1, ACMP_OFF_CTRL1, 32'h8000);
        step(8'h00, 8'h00);
        step(8'h28, 8'h00);
        bus(1'b1, ACMP_OFF_CTRL1, 32'h8040);
        step(8'h00, 8'h01);
        bus(1'b0, ACMP_OFF_CTRL1, 32'h0);
        `CHK(q, 32'h8240)
        bus(1'b0, ACMP_OFF_STATUS, 32'h0);
        `CHK(q, 32'h100)
        `CHK(irq, 1'b1)
        step(8'h28, 8'h01);
        bus(1'b1, ACMP_OFF_CTRL1, 32'h8040);
        bus(1'b1, ACMP_OFF_IRQ_STAT, 32'h1);
        step(8'h00, 8'h01);
        bus(1'b0, ACMP_OFF_STATUS, 32'h0);
        `CHK(q, 32'h0)
        `CHK(irq, 1'b0)
        step(8'h28, 8'h02);
        bus(1'b1, ACMP_OFF_CTRL1, 32'h8080);
        bus(1'b1, ACMP_OFF_IRQ_STAT, 32'h1);
        step(8'h00, 8'h03);
        bus(1'b1, ACMP_OFF_CTRL1, 32'h80c0);
        bus(1'b1, ACMP_OFF_IRQ_STAT, 32'h1);
        step(8'h28, 8'h04);
    endtask

    // idle gating only blocks while idle; mask and sticky clear
    task automatic test_irq();
        bus(1'b1, ACMP_OFF_STATUS, 32'h8000);
        repeat (3) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        idle <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        bus(1'b0, ACMP_OFF_STATUS, 32'h0);
        `CHK(q, 32'h8101)
        idle <= 1'b0;
        bus(1'b1, ACMP_OFF_IRQ_MASK, 32'h0);
        repeat (3) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        bus(1'b0, ACMP_OFF_IRQ_STAT, 32'h0);
        `CHK(q, 32'h1)
        bus(1'b1, ACMP_OFF_IRQ_STAT, 32'h1);
        bus(1'b0, ACMP_OFF_IRQ_STAT, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b1, ACMP_OFF_STATUS, 32'h0);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        test_reset();
        test_ctrl();
        test_select();
        test_event();
        test_irq();
        end_sim();
    end

    // watchdog, far beyond the several hundred cycles the run needs
    initial
    begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule // acmp_ctrl_tb
